// *** shared/adt_pkg.sv ***
// Constants, states and timing for the A/D sequencing and temperature block.
// Assumes one 50 MHz system clock and a synchronous active-high reset.
//
// Overview of operation
// - Power-on bit enables converter circuitry
// - Source select picks external or internal input
// - Two-bit field selects converter reference
// - Alignment bit sets result data format
// - Start bit low-high-low pulse begins conversion
// - Busy high during conversion, low when done
// - Power bit low switches converter off
// - Twelve-bit unsigned code, full scale FFFH
// - Transitions offset half step, last 1.5 step
// - Slope bytes at 1FF5H high, 1FF6H low
// - Offset bytes at 1FE6H and 1FE7H
// - Constants readable only with mapping enabled
// - Sensor conversion 58 clocks, others 16
// - Completion sets request flag, raises interrupt
package adt_pkg;
  // ==========================================================
  // Widths and codes
  localparam int          RES_W        = 12;
  localparam logic [11:0] FULL_SCALE   = 12'hFFF;
  localparam logic [3:0]  CH_PARK_MIN  = 4'h8;
  localparam logic [2:0]  SRC_EXTERNAL = 3'h0;
  localparam logic [2:0]  SRC_SENSOR   = 3'h4;
  localparam logic [2:0]  SRC_FORBID   = 3'h7;
  // ==========================================================
  // Conversion timing in converter clock periods
  localparam logic [5:0]  SAMPLE_EXT   = 6'h04;
  localparam logic [5:0]  SAMPLE_TS    = 6'h2E;
  localparam logic [5:0]  CONVERT_CLK  = 6'h0C;
  // ==========================================================
  // Option memory locations of calibration constants
  localparam logic [12:0] SLOPE_HI_ADR = 13'h1FF5;
  localparam logic [12:0] SLOPE_LO_ADR = 13'h1FF6;
  localparam logic [12:0] TOS_HI_ADR   = 13'h1FE6;
  localparam logic [12:0] TOS_LO_ADR   = 13'h1FE7;
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  typedef enum logic [1:0] {ADT_IDLE, ADT_SAMPLE, ADT_CONVERT} adt_state_t;
endpackage

// *** rtl/adt_clkdiv.sv ***
// Converter clock tick generator: one pulse each 2^sel system clocks.
// Assumes sel is stable while the converter runs.
`timescale 1ns/100ps
module adt_clkdiv (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);
  logic [6:0] cnt;
  logic [6:0] next_cnt;
  logic [6:0] limit;
  logic       next_tick;
  // ==========================================================
  // Divide counter
  always_comb begin
    limit     = 7'((8'h01 << sel) - 8'h01);
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = 7'h00; // Restart phase on each conversion
    end else if (cnt >= limit) begin
      next_cnt  = 7'h00;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 7'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt  <= 7'h00;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// *** rtl/adt_top.sv ***
// Sequencer for the 12-bit converter, result formatting, option memory
// window for calibration constants, and hardware temperature calculation.
// Assumes analog inputs and quantiser code arrive from outside, unsynchronised.
`timescale 1ns/100ps
module adt_top #(
  parameter logic [15:0] SLOPE_CAL = 16'h0000,
  parameter logic [11:0] TOS_CAL   = 12'h000
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [2:0]  conv_clock_divider_sel,
  input  wire logic        conv_mode_sel,
  input  wire logic        converter_power_on,
  input  wire logic [2:0]  input_source_sel,
  input  wire logic [3:0]  external_channel_sel,
  input  wire logic [1:0]  reference_source_sel,
  input  wire logic        result_alignment_sel,
  input  wire logic        global_irq_enable,
  input  wire logic        conv_irq_enable,
  input  wire logic        irq_flag_clear,
  input  wire logic        start_bit,
  input  wire logic [11:0] quantiser_code,
  input  wire logic        option_map_control,
  input  wire logic [12:0] table_addr,
  output logic             conversion_busy_flag,
  output logic             conv_irq_flag,
  output logic             conv_irq,
  output logic [7:0]       result_high_byte,
  output logic [7:0]       result_low_byte,
  output logic             analog_power,
  output logic [3:0]       analog_mux_sel,
  output logic [1:0]       analog_ref_sel,
  output logic             analog_low_current,
  output logic             analog_sample,
  output logic [7:0]       table_data,
  output logic [11:0]      temperature
);
  // ==========================================================
  // Input synchroniser for the external quantiser code
  logic [11:0] code_s1;
  logic [11:0] code_s2;
  always_ff @(posedge clock) begin
    if (reset) begin
      code_s1 <= 12'h000;
      code_s2 <= 12'h000;
    end else begin
      code_s1 <= quantiser_code;
      code_s2 <= code_s1;
    end
  end

  // ==========================================================
  // Converter clock divider
  logic tick;
  adt_clkdiv u_div (
    .clock (clock),
    .reset (reset),
    .run   (conversion_busy_flag),
    .sel   (conv_clock_divider_sel),
    .tick  (tick)
  );

  // ==========================================================
  // Conversion sequencer
  adt_pkg::adt_state_t state;
  adt_pkg::adt_state_t next_state;
  logic [5:0]  cnt;
  logic [5:0]  next_cnt;
  logic        start_q;
  logic        next_busy;
  logic        next_flag;
  logic        next_irq;
  logic        done;
  logic [11:0] res;
  logic [11:0] next_res;
  logic        is_sensor;
  logic [5:0]  sample_len;
  always_comb begin
    is_sensor  = (input_source_sel == adt_pkg::SRC_SENSOR);
    sample_len = is_sensor ? adt_pkg::SAMPLE_TS : adt_pkg::SAMPLE_EXT;
    next_state = state;
    next_cnt   = cnt;
    next_res   = res;
    done       = 1'b0;
    case (state)
      adt_pkg::ADT_IDLE: begin
        // Falling edge of start ends the pulse and launches; needs power
        if (start_q && !start_bit && converter_power_on) begin
          next_state = adt_pkg::ADT_SAMPLE;
          next_cnt   = 6'h00;
        end
      end
      adt_pkg::ADT_SAMPLE: begin
        if (tick) begin
          if (cnt == sample_len - 6'h01) begin
            next_state = adt_pkg::ADT_CONVERT;
            next_cnt   = 6'h00;
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
      end
      adt_pkg::ADT_CONVERT: begin
        if (tick) begin
          if (cnt == adt_pkg::CONVERT_CLK - 6'h01) begin
            next_state = adt_pkg::ADT_IDLE;
            next_res   = code_s2 & adt_pkg::FULL_SCALE;
            done       = 1'b1;
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
      end
      default: next_state = adt_pkg::ADT_IDLE;
    endcase
    // Power removal aborts the conversion, result kept unless power drops on the final convert tick
    if (!converter_power_on) begin
      next_state = adt_pkg::ADT_IDLE;
      done       = 1'b0;
    end
    // A rising start edge resets a running conversion
    if (!start_q && start_bit) begin
      next_state = adt_pkg::ADT_IDLE;
      done       = 1'b0;
    end
    next_busy = (next_state != adt_pkg::ADT_IDLE);
    // Set wins over a simultaneous clear
    next_flag = done | (conv_irq_flag & ~irq_flag_clear);
    next_irq  = next_flag & conv_irq_enable & global_irq_enable;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      state                <= adt_pkg::ADT_IDLE;
      cnt                  <= 6'h00;
      start_q              <= 1'b0;
      conversion_busy_flag <= 1'b0;
      conv_irq_flag        <= 1'b0;
      conv_irq             <= 1'b0;
      res                  <= 12'h000;
    end else begin
      state                <= next_state;
      cnt                  <= next_cnt;
      start_q              <= start_bit;
      conversion_busy_flag <= next_busy;
      conv_irq_flag        <= next_flag;
      conv_irq             <= next_irq;
      res                  <= next_res;
    end
  end

  // ==========================================================
  // Analog front-end controls and result formatting
  logic [7:0]  next_hi;
  logic [7:0]  next_lo;
  logic [3:0]  next_mux;
  logic        next_sample;
  always_comb begin
    // Internal sources force the parked channel code
    next_mux = (input_source_sel == adt_pkg::SRC_EXTERNAL) ? external_channel_sel
                                                           : adt_pkg::CH_PARK_MIN;
    next_sample = (state == adt_pkg::ADT_SAMPLE);
    if (result_alignment_sel) begin
      next_hi = {4'h0, res[11:8]};
      next_lo = res[7:0];
    end else begin
      next_hi = res[11:4];
      next_lo = {res[3:0], 4'h0};
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      result_high_byte   <= 8'h00;
      result_low_byte    <= 8'h00;
      analog_power       <= 1'b0;
      analog_mux_sel     <= 4'h0;
      analog_ref_sel     <= 2'h0;
      analog_low_current <= 1'b0;
      analog_sample      <= 1'b0;
    end else begin
      result_high_byte   <= next_hi;
      result_low_byte    <= next_lo;
      analog_power       <= converter_power_on;
      analog_mux_sel     <= next_mux;
      analog_ref_sel     <= reference_source_sel;
      analog_low_current <= conv_mode_sel;
      analog_sample      <= next_sample;
    end
  end

  // ==========================================================
  // Option memory window and temperature calculation
  logic [7:0]  next_tbl;
  logic [27:0] product;
  logic [15:0] diff;
  logic [11:0] next_temp;
  always_comb begin
    next_tbl = adt_pkg::RESET_BYTE;
    if (option_map_control) begin
      case (table_addr)
        adt_pkg::SLOPE_HI_ADR: next_tbl = SLOPE_CAL[15:8];
        adt_pkg::SLOPE_LO_ADR: next_tbl = SLOPE_CAL[7:0];
        adt_pkg::TOS_HI_ADR:   next_tbl = TOS_CAL[11:4];
        adt_pkg::TOS_LO_ADR:   next_tbl = {4'h0, TOS_CAL[3:0]};
        default:               next_tbl = adt_pkg::RESET_BYTE;
      endcase
    end
    product   = SLOPE_CAL * res;
    diff      = product[27:12] - {4'h0, TOS_CAL};
    next_temp = diff[11:0];
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      table_data  <= adt_pkg::RESET_BYTE;
      temperature <= 12'h000;
    end else begin
      table_data  <= next_tbl;
      temperature <= next_temp;
    end
  end

  // ==========================================================
  // Checks
  // Start pulse: rise, then fall with power present
  sequence s_start_pulse;
    !start_q && start_bit ##1 start_q && !start_bit && converter_power_on;
  endsequence
  a_busy_after_start: assert property (@(posedge clock) disable iff (reset)
    s_start_pulse |=> conversion_busy_flag) else $error("busy not set");
  a_done_sets_flag: assert property (@(posedge clock) disable iff (reset)
    done |=> conv_irq_flag && !conversion_busy_flag) else $error("flag not set");
  a_irq_gated: assert property (@(posedge clock) disable iff (reset)
    conv_irq |-> $past(conv_irq_enable) && $past(global_irq_enable))
    else $error("irq ungated");
  a_power_off_idle: assert property (@(posedge clock) disable iff (reset)
    !converter_power_on |=> !conversion_busy_flag && !analog_power)
    else $error("power off busy");
  a_right_pad_zero: assert property (@(posedge clock) disable iff (reset)
    $past(result_alignment_sel) |-> result_high_byte[7:4] == 4'h0)
    else $error("right pad");
  a_left_pad_zero: assert property (@(posedge clock) disable iff (reset)
    !$past(result_alignment_sel) |-> result_low_byte[3:0] == 4'h0)
    else $error("left pad");
  a_map_closed: assert property (@(posedge clock) disable iff (reset)
    !$past(option_map_control) |-> table_data == adt_pkg::RESET_BYTE)
    else $error("map leak");
  a_internal_park: assert property (@(posedge clock) disable iff (reset)
    $past(input_source_sel) != adt_pkg::SRC_EXTERNAL
    |-> analog_mux_sel == adt_pkg::CH_PARK_MIN) else $error("mux not parked");
  a_ref_follows: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> analog_ref_sel == $past(reference_source_sel)) else $error("ref");
  a_sample_len: assert property (@(posedge clock) disable iff (reset)
    state == adt_pkg::ADT_SAMPLE && tick && cnt == adt_pkg::SAMPLE_EXT - 6'h01
    && !is_sensor && converter_power_on && !(!start_q && start_bit)
    |=> state == adt_pkg::ADT_CONVERT) else $error("sample length");
endmodule

// *** tb/adt_quant_model.sv ***
// Behavioural quantiser on the analog side of the sequencer.
// Assumes the bench picks the code that the analog input would give.
`timescale 1ns/100ps
module adt_quant_model (
  input  wire logic        clock,
  input  wire logic        analog_power,
  input  wire logic [11:0] target_code,
  output logic [11:0]      quantiser_code
);
  // ==========================================================
  // Quantiser output
  // Unpowered output is junk, so it flips each cycle rather than hold
  initial quantiser_code = 12'h000;
  always @(posedge clock) begin
    if (analog_power) begin
      quantiser_code <= target_code;
    end else begin
      quantiser_code <= ~quantiser_code;
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the converter sequencer: timing, formats, window.
// Assumes the quantiser model drives the code input of the block.
`timescale 1ns/100ps
module tb_top;
  // ==========================================================
  // Stimulus and observed signals
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [2:0]  div_sel = 3'h0;
  logic        mode_sel = 1'b0;
  logic        power_on = 1'b0;
  logic [2:0]  src_sel = 3'h0;
  logic [3:0]  chan_sel = 4'h0;
  logic [1:0]  ref_sel = 2'h0;
  logic        align_sel = 1'b0;
  logic        gie = 1'b0;
  logic        cie = 1'b0;
  logic        flag_clear = 1'b0;
  logic        start_bit = 1'b0;
  logic        map_on = 1'b0;
  logic [12:0] taddr = 13'h0000;
  logic [11:0] target = 12'h000;
  logic [11:0] qcode;
  logic        busy, flag, irq, apower, asample, alow;
  logic [7:0]  res_hi, res_lo, tdata;
  logic [3:0]  amux;
  logic [1:0]  aref;
  logic [11:0] temp;
  int          mismatches = 0;
  int          num_checks = 0;
  int          cycles = 0;
  logic [12:0] addrs [6] = '{13'h1FF5, 13'h1FF6, 13'h1FE6, 13'h1FE7, 13'h1FF0, 13'h1FF5};
  logic [7:0]  bytes [6] = '{8'h0A, 8'hB9, 8'h40, 8'h07, 8'h00, 8'h00};

  always #10 clock = ~clock;

  adt_top #(.SLOPE_CAL(16'h0AB9), .TOS_CAL(12'h407)) adt_top_i (
    .clock(clock), .reset(reset), .conv_clock_divider_sel(div_sel),
    .conv_mode_sel(mode_sel), .converter_power_on(power_on),
    .input_source_sel(src_sel), .external_channel_sel(chan_sel),
    .reference_source_sel(ref_sel), .result_alignment_sel(align_sel),
    .global_irq_enable(gie), .conv_irq_enable(cie), .irq_flag_clear(flag_clear),
    .start_bit(start_bit), .quantiser_code(qcode), .option_map_control(map_on),
    .table_addr(taddr), .conversion_busy_flag(busy), .conv_irq_flag(flag),
    .conv_irq(irq), .result_high_byte(res_hi), .result_low_byte(res_lo),
    .analog_power(apower), .analog_mux_sel(amux), .analog_ref_sel(aref),
    .analog_low_current(alow), .analog_sample(asample), .table_data(tdata),
    .temperature(temp));

  adt_quant_model adt_quant_model_i (
    .clock(clock), .analog_power(apower), .target_code(target),
    .quantiser_code(qcode));

  // ==========================================================
  // Shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Start bit goes low-high-low on successive edges
  task automatic pulse();
    @(posedge clock) start_bit <= 1'b1;
    @(posedge clock) start_bit <= 1'b0;
  endtask

  // Busy length gets a window of two or three cycles around the nominal count
  task automatic conv(input int lo, input int hi);
    int n;
    n = 0;
    pulse();
    @(posedge clock);
    #1 chk("busy_rise", 16'h1, busy);
    while (busy === 1'b1 && n < 400) begin
      @(posedge clock);
      #1 n++;
      if (n == 1) begin
        chk("sample_on", 16'h1, asample);
      end
    end
    chk("sample_off", 16'h0, asample);
    chk("busy_len", 16'h1, (n >= lo && n <= hi));
  endtask

  task automatic clr_flag();
    @(posedge clock) flag_clear <= 1'b1;
    @(posedge clock) flag_clear <= 1'b0;
    #1 chk("flag_clr", 16'h0, flag);
  endtask

  // Hang guard at about six times the few hundred cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    #1 chk("busy_rst", 16'h0, busy);
    chk("res_rst", 16'h0, {res_hi, res_lo});
    @(posedge clock);
    mode_sel <= 1'b1;
    power_on <= 1'b1;
    chan_sel <= 4'h3;
    ref_sel  <= 2'h2;
    cie      <= 1'b1;
    repeat (3) @(posedge clock);
    #1 chk("power", 16'h1, apower);
    chk("mux_ext", 16'h3, amux);
    chk("ref", 16'h2, aref);
    chk("low_cur", 16'h1, alow);
    // External conversions: formats, full scale, interrupt gating
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      align_sel <= (i != 1);
      gie       <= (i != 1);
      target    <= (i == 2) ? 12'hFFF : 12'hABC;
      conv(14, 18);
      chk("flag_set", 16'h1, flag);
      chk("irq_out", {15'h0, i != 1}, irq);
      @(posedge clock);
      #1 chk("result", align_sel ? {4'h0, target} : {target, 4'h0},
             {res_hi, res_lo});
      clr_flag();
    end
    // Sensor path: channel parked before the source switches
    @(posedge clock) chan_sel <= 4'h8;
    @(posedge clock);
    src_sel <= adt_pkg::SRC_SENSOR;
    div_sel <= 3'h1;
    target  <= 12'h514;
    repeat (3) @(posedge clock);
    #1 chk("mux_int", 16'h8, amux);
    conv(114, 119);
    repeat (3) @(posedge clock);
    // Slope 0AB9, offset 407 and code 514 give minus ten degrees
    #1 chk("temp", 16'h0F60, {4'h0, temp});
    clr_flag();
    // Power off: start ignored, then an abort mid-conversion
    @(posedge clock);
    power_on <= 1'b0;
    src_sel  <= adt_pkg::SRC_EXTERNAL;
    div_sel  <= 3'h2;
    pulse();
    repeat (3) @(posedge clock);
    #1 chk("busy_off", 16'h0, busy);
    chk("power_off", 16'h0, apower);
    @(posedge clock) power_on <= 1'b1;
    repeat (4) @(posedge clock);
    pulse();
    @(posedge clock);
    #1 chk("busy_run", 16'h1, busy);
    @(posedge clock) power_on <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("busy_abort", 16'h0, busy);
    chk("flag_abort", 16'h0, flag);
    // Restart: a rising start mid-run aborts, its fall relaunches
    @(posedge clock) power_on <= 1'b1;
    repeat (4) @(posedge clock);
    pulse();
    repeat (3) @(posedge clock);
    pulse();
    #1 chk("busy_restart", 16'h0, busy);
    chk("flag_restart", 16'h0, flag);
    repeat (80) @(posedge clock);
    #1 chk("flag_relaunch", 16'h1, flag);
    chk("busy_relaunch", 16'h0, busy);
    chk("res_relaunch", 16'h0514, {res_hi, res_lo});
    // Calibration window: mapped bytes, a hole, then window closed
    for (int j = 0; j < 6; j++) begin
      @(posedge clock);
      map_on <= (j < 5);
      taddr  <= addrs[j];
      repeat (2) @(posedge clock);
      #1 chk("table", {8'h0, bytes[j]}, {8'h0, tdata});
    end
    print_verdict();
  end
endmodule
